// [logic/csrb_command_status_bank.v]
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "csrb_defs.vh"
module csrb_command_status_bank #(
   parameter [5:0] FEATURE_SET = 6'h00,
   // arbitrary neutral value
   parameter [3:0] PART_CODE = 4'hA
) (
   // clock and reset
   input wire clk,
   input wire rst,
   // command executed pulses, same clock domain
   input wire continuous_read_command,
   input wire stop_continuous_read_command,
   input wire queue_read_command,
   input wire register_write_command,
   input wire register_read_command,
   input wire offset_calibrate_command,
   input wire single_read_command,
   input wire lock_command,
   input wire unlock_command,
   input wire start_command,
   input wire stop_command,
   input wire standby_command,
   input wire wakeup_command,
   // asynchronous inputs
   input wire start_pin,
   input wire fuse_uncorrectable_flag,
   input wire fuse_correctable_flag,
   // offset value to datapath
   output reg [7:0] offset_cal_value,
   // axi4-lite write address
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // axi4-lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // axi4-lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read address
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // axi4-lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);
   reg [1:0] fuse_meta;
   reg [1:0] fuse_sync;
   reg pin_meta;
   reg pin_sync;
   reg start_pin_prev;
   reg [5:0] cmd_flags;
   reg locked;
   reg [5:0] sys_low;
   reg [5:0] next_sys_low;
   reg aw_held;
   reg [7:0] aw_addr;
   reg w_held;
   reg [7:0] w_byte;
   reg w_lane;
   reg [7:0] rd_byte;
   wire start_event;
   wire [5:0] cmd_events;
   wire [7:0] cmd_status;
   wire [7:0] sys_status;
   wire [7:0] feature_value;
   wire [7:0] part_value;
   wire do_write;
   wire wr_aligned;
   wire wr_sel_cmd;
   wire wr_sel_sys;
   wire wr_sel_feature;
   wire wr_sel_part;
   wire wr_sel_ofc0;
   wire wr_hit;
   wire ofc0_load;
   wire rd_aligned;
   wire rd_sel_cmd;
   wire rd_sel_sys;
   wire rd_sel_feature;
   wire rd_sel_part;
   wire rd_sel_ofc0;
   wire rd_hit;
   wire rd_take;

   // fuse levels pass two flops; first stage read only by the second
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         fuse_meta <= 2'b00;
         fuse_sync <= 2'b00;
      end else begin
         fuse_meta <= {fuse_uncorrectable_flag, fuse_correctable_flag};
         fuse_sync <= fuse_meta;
      end
   end

   // start pin: same two flops, then one more to find the edge
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_meta <= 1'b0;
         pin_sync <= 1'b0;
         start_pin_prev <= 1'b0;
      end else begin
         pin_meta <= start_pin;
         pin_sync <= pin_meta;
         start_pin_prev <= pin_sync;
      end
   end

   // rising edge counts as a start event; a held level is one event
   assign start_event = pin_sync & ~start_pin_prev;

   assign cmd_events = {continuous_read_command, queue_read_command, offset_calibrate_command,
                        single_read_command, register_write_command, register_read_command};

   // sticky executed flags, no clear path but reset
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi = gi + 1) begin : g_cmd
         always @(posedge clk or posedge rst) begin
            if (rst) begin
               cmd_flags[gi] <= 1'b0;
            end else if (cmd_events[gi]) begin
               cmd_flags[gi] <= 1'b1;
            end
         end
      end
   endgenerate

   // fuse bits follow the synchronised flags
   assign cmd_status = {fuse_sync[1], fuse_sync[0], cmd_flags};
   // bits 5:0 from cmd_flags

   // mode bits; when both set and clear arrive, set wins
   always @* begin
      next_sys_low = sys_low;
      if (continuous_read_command) begin
         next_sys_low[`CSRB_SYS_STOP_CONT] = 1'b0;
      end
      if (stop_continuous_read_command) begin
         next_sys_low[`CSRB_SYS_STOP_CONT] = 1'b1;
      end
      if (stop_continuous_read_command) begin
         next_sys_low[`CSRB_SYS_CONT] = 1'b0;
      end
      if (continuous_read_command) begin
         next_sys_low[`CSRB_SYS_CONT] = 1'b1;
      end
      if (start_command | start_event) begin
         next_sys_low[`CSRB_SYS_STOPPED] = 1'b0;
      end
      if (stop_command) begin
         next_sys_low[`CSRB_SYS_STOPPED] = 1'b1;
      end
      if (start_command | start_event) begin
         next_sys_low[`CSRB_SYS_STARTED] = 1'b1;
      end
      if (standby_command) begin
         next_sys_low[`CSRB_SYS_AWAKE] = 1'b0;
      end
      if (wakeup_command) begin
         next_sys_low[`CSRB_SYS_AWAKE] = 1'b1;
      end
      if (wakeup_command) begin
         next_sys_low[`CSRB_SYS_STANDBY] = 1'b0;
      end
      if (standby_command) begin
         next_sys_low[`CSRB_SYS_STANDBY] = 1'b1;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sys_low <= `CSRB_SYS_LOW_RESET;
      end else begin
         sys_low <= next_sys_low;
      end
   end

   // lock wins over unlock when both arrive together
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         locked <= `CSRB_LOCKED_RESET;
      end else if (lock_command) begin
         locked <= 1'b1;
      end else if (unlock_command) begin
         locked <= 1'b0;
      end
   end

   // one flop drives both, so they can never disagree
   assign sys_status = {~locked, locked, sys_low};

   // fixed identification fields; upper feature bits are reserved zero
   assign feature_value = {2'b00, FEATURE_SET};
   assign part_value = {PART_CODE, 4'h0};

   // selects from the held write address; unaligned addresses select nothing
   assign wr_aligned = (aw_addr[1:0] == 2'b00);
   assign wr_sel_cmd = wr_aligned & (aw_addr[7:2] == `CSRB_IDX_CMD_STAT);
   assign wr_sel_sys = wr_aligned & (aw_addr[7:2] == `CSRB_IDX_SYS_STAT);
   assign wr_sel_feature = wr_aligned & (aw_addr[7:2] == `CSRB_IDX_FEATURE);
   assign wr_sel_part = wr_aligned & (aw_addr[7:2] == `CSRB_IDX_PART);
   assign wr_sel_ofc0 = wr_aligned & (aw_addr[7:2] == `CSRB_IDX_OFC0);
   // read-only registers accept writes with okay and keep their value
   assign wr_hit = wr_sel_cmd | wr_sel_sys | wr_sel_feature | wr_sel_part | wr_sel_ofc0;
   assign ofc0_load = do_write & wr_sel_ofc0 & w_lane;

   // write channel: address and data taken in either order
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held & ~s_axi_bvalid;
   assign do_write = aw_held & w_held & ~s_axi_bvalid;

   // write address holder; a take and a release never meet in one cycle
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
      end else if (s_axi_awvalid & s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   // write data holder; only lane 0 matters to an 8-bit register
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         w_held <= 1'b0;
         w_byte <= 8'h00;
         w_lane <= 1'b0;
      end else if (s_axi_wvalid & s_axi_wready) begin
         w_held <= 1'b1;
         w_byte <= s_axi_wdata[7:0];
         w_lane <= s_axi_wstrb[0];
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end

   // response stands until the master takes it
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `CSRB_AXI_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? `CSRB_AXI_OKAY : `CSRB_AXI_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // other strobes leave the byte alone, so a stray wide write is harmless
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         offset_cal_value <= `CSRB_OFC0_RESET;
      end else if (ofc0_load) begin
         offset_cal_value <= w_byte;
      end
   end

   // read selects straight from the offered address
   assign rd_aligned = (s_axi_araddr[1:0] == 2'b00);
   assign rd_sel_cmd = rd_aligned & (s_axi_araddr[7:2] == `CSRB_IDX_CMD_STAT);
   assign rd_sel_sys = rd_aligned & (s_axi_araddr[7:2] == `CSRB_IDX_SYS_STAT);
   assign rd_sel_feature = rd_aligned & (s_axi_araddr[7:2] == `CSRB_IDX_FEATURE);
   assign rd_sel_part = rd_aligned & (s_axi_araddr[7:2] == `CSRB_IDX_PART);
   assign rd_sel_ofc0 = rd_aligned & (s_axi_araddr[7:2] == `CSRB_IDX_OFC0);
   assign rd_hit = rd_sel_cmd | rd_sel_sys | rd_sel_feature | rd_sel_part | rd_sel_ofc0;

   // selects are one-hot, so the chain order does not matter
   always @* begin
      rd_byte = 8'h00;
      if (rd_sel_cmd) begin
         rd_byte = cmd_status;
      end else if (rd_sel_sys) begin
         rd_byte = sys_status;
      end else if (rd_sel_feature) begin
         rd_byte = feature_value;
      end else if (rd_sel_part) begin
         rd_byte = part_value;
      end else if (rd_sel_ofc0) begin
         rd_byte = offset_cal_value;
      end
   end

   assign s_axi_arready = ~s_axi_rvalid;
   assign rd_take = s_axi_arvalid & s_axi_arready;

   // read answer stands until the master takes it
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
      end else if (rd_take) begin
         s_axi_rvalid <= 1'b1;
      end else if (s_axi_rvalid & s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // data is a snapshot at the take; later status changes wait for the next read
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `CSRB_AXI_OKAY;
      end else if (rd_take) begin
         s_axi_rdata <= {24'h000000, rd_byte};
         s_axi_rresp <= rd_hit ? `CSRB_AXI_OKAY : `CSRB_AXI_SLVERR;
      end
   end
endmodule

// [logic/csrb_defs.vh]
`ifndef CSRB_DEFS_VH
`define CSRB_DEFS_VH
// register indices; byte address is four times the index
`define CSRB_IDX_CMD_STAT 6'h1B
`define CSRB_IDX_SYS_STAT 6'h1C
`define CSRB_IDX_FEATURE 6'h1D
`define CSRB_IDX_PART 6'h1E
`define CSRB_IDX_OFC0 6'h22
// command status bit positions
`define CSRB_CMD_FUSE_UNCORR 7
`define CSRB_CMD_FUSE_CORR 6
`define CSRB_CMD_CONT_READ 5
`define CSRB_CMD_QUEUE_READ 4
`define CSRB_CMD_CAL 3
`define CSRB_CMD_SINGLE_READ 2
`define CSRB_CMD_REG_WRITE 1
`define CSRB_CMD_REG_READ 0
// system status bit positions
`define CSRB_SYS_UNLOCKED 7
`define CSRB_SYS_LOCKED 6
`define CSRB_SYS_STOP_CONT 5
`define CSRB_SYS_CONT 4
`define CSRB_SYS_STOPPED 3
`define CSRB_SYS_STARTED 2
`define CSRB_SYS_AWAKE 1
`define CSRB_SYS_STANDBY 0
// reset values
`define CSRB_CMD_RESET 6'h00
`define CSRB_LOCKED_RESET 1'b0
`define CSRB_SYS_LOW_RESET 6'h12
`define CSRB_OFC0_RESET 8'h00
// field position of the part register
`define CSRB_PART_LSB 4
`define CSRB_AXI_OKAY 2'h0
`define CSRB_AXI_SLVERR 2'h2
`endif

// [test/csrb_command_status_bank_assertions.sv]
`timescale 1ns/1ps
module csrb_checker #(
   parameter [5:0] FEATURE_SET = 6'h00,
   // arbitrary neutral value
   parameter [3:0] PART_CODE = 4'hA
) (
   // clock and reset
   input wire clk,
   input wire rst,
   // watched ports
   input wire [7:0] offset_cal_value,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   a_bresp_held:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_rdata_held:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   a_read_answer:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
   a_write_answer:
      assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |-> ##[1:2] s_axi_bvalid) else $error("no write answer");
   a_write_refused:
      assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken");
   a_offset_cause:
      assert property ($changed(offset_cal_value) |-> s_axi_bvalid) else $error("offset moved");
   a_feature_read:
      assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h74
         |=> s_axi_rdata == {26'h0, FEATURE_SET}) else $error("feature value wrong");
   a_part_read:
      assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h78
         |=> s_axi_rdata == {24'h0, PART_CODE, 4'h0}) else $error("part value wrong");
   a_lock_pair:
      assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h70
         |=> s_axi_rdata[7] != s_axi_rdata[6]) else $error("lock bits equal");
endmodule
bind csrb_command_status_bank csrb_checker #(.FEATURE_SET(FEATURE_SET), .PART_CODE(PART_CODE))
   u_csrb_checker (.clk, .rst, .offset_cal_value, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// [test/csrb_host_model.sv]
`timescale 1ns/1ps
module csrb_host_model (
   // clock
   input wire clk,
   // one-cycle command executed strobes
   output logic [12:0] cmd
);
   initial cmd = 13'h0000;
   task automatic issue(input int i);
      @(posedge clk);
      cmd <= 13'h0001 << i;
      @(posedge clk);
      cmd <= 13'h0000;
   endtask
endmodule

// [test/csrb_command_status_bank_bench.sv]
`timescale 1ns/1ps
module csrb_command_status_bank_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic fuse_unc = 1'b0;
   logic fuse_cor = 1'b0;
   logic start_pin = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [7:0] offset_val;
   wire [12:0] cmd;
   int mismatches = 0;
   int check_count = 0;
   int seq[14] = '{1, 0, 2, 3, 4, 5, 6, 7, 8, 10, 9, 11, 12, 10};
   logic [7:0] ec[14] = '{8'h00, 8'h20, 8'h30, 8'h32, 8'h33, 8'h3B, 8'h3F, 8'h3F, 8'h3F,
      8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h3F};
   logic [7:0] es[14] = '{8'hA2, 8'h92, 8'h92, 8'h92, 8'h92, 8'h92, 8'h92, 8'h52, 8'h92,
      8'h9A, 8'h96, 8'h95, 8'h96, 8'h9E};
   always #2.5 clk = ~clk;
   csrb_host_model u_csrb_host_model (.clk(clk), .cmd(cmd));
   csrb_command_status_bank #(.FEATURE_SET(6'h15), .PART_CODE(4'h5)) u_csrb_command_status_bank (
      .clk, .rst, .continuous_read_command(cmd[0]), .stop_continuous_read_command(cmd[1]),
      .queue_read_command(cmd[2]), .register_write_command(cmd[3]),
      .register_read_command(cmd[4]), .offset_calibrate_command(cmd[5]),
      .single_read_command(cmd[6]), .lock_command(cmd[7]), .unlock_command(cmd[8]),
      .start_command(cmd[9]), .stop_command(cmd[10]), .standby_command(cmd[11]),
      .wakeup_command(cmd[12]), .start_pin, .fuse_uncorrectable_flag(fuse_unc),
      .fuse_correctable_flag(fuse_cor), .offset_cal_value(offset_val), .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   task automatic stop_test;
      $display("mismatches %0d, checks %0d", mismatches, check_count);
      if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input [31:0] seen, input [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // valids drop only at the edge that takes them; bound the wait for the answer
   task automatic wr(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
      int n;
      @(posedge clk);
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      for (n = 0; n < 40 && !s_axi_bvalid; n++) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      if (!s_axi_bvalid) mismatches++;
      if (!s_axi_bvalid) stop_test;
      chk(s_axi_bresp, er);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input [7:0] a, input [31:0] e, input [1:0] er);
      int n;
      @(posedge clk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      for (n = 0; n < 40 && !s_axi_rvalid; n++) begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      if (!s_axi_rvalid) mismatches++;
      if (!s_axi_rvalid) stop_test;
      chk(s_axi_rdata, e);
      chk(s_axi_rresp, er);
      s_axi_rready <= 1'b0;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd(8'h6C, 32'h0, 2'h0);
      rd(8'h70, 32'h92, 2'h0);
      rd(8'h74, 32'h15, 2'h0);
      rd(8'h78, 32'h50, 2'h0);
      wr(8'h88, 32'hFFFF_FFA5, 4'h1, 2'h0);
      wr(8'h88, 32'h3C, 4'h2, 2'h0);
      rd(8'h88, 32'hA5, 2'h0);
      chk(offset_val, 32'hA5);
      wr(8'h70, 32'h0, 4'hF, 2'h0);
      wr(8'h78, 32'hFF, 4'hF, 2'h0);
      wr(8'h6C, 32'hFF, 4'hF, 2'h0);
      wr(8'h04, 32'h11, 4'h1, 2'h2);
      wr(8'h89, 32'h11, 4'h1, 2'h2);
      rd(8'h04, 32'h0, 2'h2);
      rd(8'h89, 32'h0, 2'h2);
      rd(8'h6C, 32'h0, 2'h0);
      rd(8'h70, 32'h92, 2'h0);
      rd(8'h78, 32'h50, 2'h0);
      chk(offset_val, 32'hA5);
      for (int i = 0; i < 14; i++) begin
         u_csrb_host_model.issue(seq[i]);
         rd(8'h6C, ec[i], 2'h0);
         rd(8'h70, es[i], 2'h0);
      end
      start_pin <= 1'b1;
      repeat (4) @(posedge clk);
      rd(8'h70, 32'h96, 2'h0);
      fuse_unc <= 1'b1;
      repeat (4) @(posedge clk);
      rd(8'h6C, 32'hBF, 2'h0);
      {fuse_unc, fuse_cor} <= 2'h1;
      repeat (4) @(posedge clk);
      rd(8'h6C, 32'h7F, 2'h0);
      {fuse_unc, fuse_cor, start_pin} <= 3'h0;
      rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd(8'h6C, 32'h0, 2'h0);
      rd(8'h70, 32'h92, 2'h0);
      chk(offset_val, 32'h0);
      stop_test;
   end
endmodule
